// ===== dv/tb_t2c_timer.sv
/*
 * self-checking testbench for t2c_timer: strobes, pins and interrupt sources.
 * assumes t2c_pkg and the design modules are compiled first; no checker file.
 */
`timescale 1ns/10ps

module tb_t2c_timer;
	import t2c_pkg::*;
	// =============================================================
	// signals
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] wr_data = 8'h00;
	logic [4:0] stb = 5'h00; // ctl, cnt lo, cnt hi, rld lo, rld hi
	logic cnt_pin = 1'b1;
	logic trg_pin = 1'b1;
	logic [5:0] src = 6'h00;
	logic [7:0] ctl_rd;
	logic [15:0] count_rd;
	logic [15:0] reload_rd;
	logic [15:0] int_vector;
	logic timer_irq;
	logic int_pending;
	logic rx_baud_tick;
	logic tx_baud_tick;
	logic [15:0] v;
	int error_cnt = 0;
	int total_checks = 0;
	int cycles = 0;
	int n;

	// short machine cycle keeps the counting tests quick
	t2c_timer #(.MACH_DIV(4)) i_dut (
		.clk(clk), .reset(reset), .wr_data(wr_data),
		.ctl_wr(stb[0]), .cnt_lo_wr(stb[1]), .cnt_hi_wr(stb[2]),
		.rld_lo_wr(stb[3]), .rld_hi_wr(stb[4]),
		.ctl_rd(ctl_rd), .count_rd(count_rd), .reload_rd(reload_rd),
		.count_input_pin(cnt_pin), .trigger_input_pin(trg_pin),
		.ext_int_zero_flag(src[0]), .timer_zero_overflow(src[1]),
		.ext_int_one_flag(src[2]), .timer_one_overflow(src[3]),
		.serial_receive_flag(src[4]), .serial_transmit_flag(src[5]),
		.timer_irq(timer_irq), .int_pending(int_pending), .int_vector(int_vector),
		.rx_baud_tick(rx_baud_tick), .tx_baud_tick(tx_baud_tick)
	);

	// =============================================================
	// clock and hang guard
	always #25 clk = ~clk;
	// longest test is the baud check, two baud intervals of 512 cycles each
	always @(posedge clk) begin
		cycles++;
		if (cycles == 6000) begin
			error_cnt++;
			tally_and_finish();
		end
	end

	// =============================================================
	// tasks
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask

	// one-cycle strobe; the next call waits a further falling edge
	task automatic wr(input int idx, input logic [7:0] d);
		@(negedge clk);
		stb[idx] = 1'b1;
		wr_data = d;
		@(negedge clk);
		stb = 5'h00;
	endtask

	// low and high phases well above the synchroniser minimum
	task automatic pulse(input logic trig);
		if (trig) begin
			trg_pin = 1'b0;
		end else begin
			cnt_pin = 1'b0;
		end
		cyc(4);
		trg_pin = 1'b1;
		cnt_pin = 1'b1;
		cyc(4);
	endtask

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// =============================================================
	// main sequence
	initial begin
		cyc(5);
		reset = 1'b0;
		cyc(1);
		check(ctl_rd, 8'h00);
		check(count_rd, 16'h0000);
		check(reload_rd, 16'h0000);
		check(int_pending, 1'b0);
		// software-set flags request like hardware ones
		wr(0, 8'h80);
		cyc(2);
		check(timer_irq, 1'b1);
		check(int_pending, 1'b1);
		check(int_vector, VEC_TMR2);
		wr(0, 8'h40);
		cyc(2);
		check(timer_irq, 1'b1);
		wr(0, 8'h00);
		cyc(3);
		check(timer_irq, 1'b0);
		check(int_pending, 1'b0);
		// each source with all lower ones pending
		for (int i = 0; i < 6; i++) begin
			src = 6'h3F << i;
			cyc(2);
			check(int_vector, 16'h0003 + 16'(8 * ((i > 4) ? 4 : i)));
		end
		src = 6'h00;
		// auto-reload: mode first, run bit in its own write
		wr(3, 8'h34);
		wr(4, 8'h12);
		wr(1, 8'hFE);
		wr(2, 8'hFF);
		wr(0, 8'h00);
		wr(0, 8'h04);
		n = 0;
		while (ctl_rd[7] !== 1'b1 && n < 100) begin
			cyc(1);
			n++;
		end
		check(count_rd, 16'h1234);
		cyc(2);
		check(ctl_rd[7], 1'b1);
		check(int_vector, VEC_TMR2);
		check(int_pending, 1'b1);
		// machine-cycle rate: ten ticks in forty clocks
		v = count_rd;
		n = 0;
		while (count_rd === v && n < 20) begin
			cyc(1);
			n++;
		end
		v = count_rd;
		cyc(40);
		check(count_rd, v + 16'h000A);
		// capture, first without trigger enable
		wr(0, 8'h00);
		wr(1, 8'h00);
		wr(2, 8'h05);
		wr(0, 8'h01);
		wr(0, 8'h05);
		v = reload_rd;
		pulse(1'b1);
		check(reload_rd, v);
		check(ctl_rd[6], 1'b0);
		wr(0, 8'h0D);
		pulse(1'b1);
		check(ctl_rd[6], 1'b1);
		check(reload_rd >= 16'h0500 && reload_rd <= count_rd, 1'b1);
		// counter function counts pin falls
		wr(0, 8'h00);
		wr(1, 8'h00);
		wr(2, 8'h00);
		wr(3, 8'h78);
		wr(4, 8'h56);
		wr(0, 8'h02);
		wr(0, 8'h06);
		repeat (5) pulse(1'b0);
		check(count_rd, 16'h0005);
		// trigger in auto-reload mode loads the reload bytes
		wr(0, 8'h0A);
		wr(0, 8'h0E);
		pulse(1'b1);
		check(count_rd, 16'h5678);
		check(ctl_rd[6], 1'b1);
		// baud mode trigger: flag only, no reload; stop before touching bytes
		wr(0, 8'h00);
		wr(3, 8'hF0);
		wr(4, 8'hFF);
		wr(0, 8'h3C);
		pulse(1'b1);
		check(ctl_rd[6], 1'b1);
		wr(0, 8'h00);
		check(count_rd < 16'hFFF0, 1'b1);
		// baud ticks: 16 rollovers of 16 state times
		wr(1, 8'hF0);
		wr(2, 8'hFF);
		wr(0, 8'h34);
		n = 0;
		while (rx_baud_tick !== 1'b1 && n < 1200) begin
			cyc(1);
			n++;
		end
		check(tx_baud_tick, 1'b1);
		n = 0;
		do begin
			cyc(1);
			n++;
		end while (rx_baud_tick !== 1'b1 && n < 1200);
		check(16'(n), 16'h0200);
		check(ctl_rd[7], 1'b0);
		check(timer_irq, 1'b0);
		tally_and_finish();
	end
endmodule // tb_t2c_timer

// ===== hw/t2c_edge_sync.sv
/*
 * two-flop synchroniser with a registered falling-edge detector.
 * assumes pin_in is asynchronous to clk; fall_pulse is one clk cycle wide.
 */
`timescale 1ns/10ps

module t2c_edge_sync (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// pin side
	input wire logic pin_in,
	// logic side
	output logic fall_pulse
);
	logic meta_q;
	logic sync_q;
	logic last_q;

	// meta_q is read only by sync_q; idle pins sit high, so reset to one
	always_ff @(posedge clk) begin
		if (reset) begin
			meta_q <= 1'b1;
			sync_q <= 1'b1;
			last_q <= 1'b1;
		end else begin
			meta_q <= pin_in;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	// registered so the edge reaches the timer straight from a flop
	always_ff @(posedge clk) begin
		if (reset) begin
			fall_pulse <= 1'b0;
		end else begin
			fall_pulse <= last_q & ~sync_q;
		end
	end
endmodule // t2c_edge_sync

// ===== hw/t2c_timer.sv
/*
 * third 16-bit timer/counter: package of constants and the timer itself,
 * with capture, auto-reload and baud generation, flags and vectoring.
 * assumes clk is the oscillator and software reaches the bytes by the
 * write strobes and read outputs below; pins are asynchronous.
 */
`timescale 1ns/10ps
// =====================================================================
// Notes on behaviour
// - run set: no clock selects and capture bit clear reloads, capture bit captures.
// - baud mode rollover never sets overflow flag nor raises interrupt.
// - baud mode trigger edge sets event flag but does not reload.
// - baud mode timer function counts every state time.
// - externally clocked baud: bit rate is overflow rate over 16.
// - internal baud: bit rate is oscillator over 32 times (65536 minus reload).
// - interrupt request is OR of overflow and event flags.
// - vectoring clears neither flag; software finds and clears the cause.
// - software writes to flags act exactly like hardware set or clear.
// - six sources, fixed priority, vectors 0003H upward by 8, this one 002BH.
// - trigger edge captures or reloads too, except in baud mode.
// - capture trigger copies count bytes to reload bytes, sets event flag.
// - auto-reload rollover sets overflow flag and loads reload value.
// - outside baud mode, timer function counts once per twelve oscillator cycles.
// - control bits 7..0: ovf, event, rx clk, tx clk, trig en, run, c/t, cap.
// =====================================================================
package t2c_pkg;
	// control register field positions
	localparam int CTL_OVF = 7;
	localparam int CTL_EVT = 6;
	localparam int CTL_RXCLK = 5;
	localparam int CTL_TXCLK = 4;
	localparam int CTL_TRIG_EN = 3;
	localparam int CTL_RUN = 2;
	localparam int CTL_CT = 1;
	localparam int CTL_CAP = 0;
	// reset values and count maximum
	localparam logic [7:0] CTL_RESET = 8'h00;
	localparam logic [15:0] CNT_RESET = 16'h0000;
	localparam logic [15:0] RLD_RESET = 16'h0000;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	// timing counts in oscillator cycles
	localparam int MACHINE_CYCLES = 12;
	localparam int STATE_CYCLES = 2;
	localparam logic [3:0] BAUD_LAST = 4'hF; // sixteen overflows per bit
	// interrupt vectors, highest priority first
	localparam logic [15:0] VEC_EXT0 = 16'h0003;
	localparam logic [15:0] VEC_TMR0 = 16'h000B;
	localparam logic [15:0] VEC_EXT1 = 16'h0013;
	localparam logic [15:0] VEC_TMR1 = 16'h001B;
	localparam logic [15:0] VEC_SER = 16'h0023;
	localparam logic [15:0] VEC_TMR2 = 16'h002B;

	typedef enum logic [3:0] {
		T2C_OFF = 4'h1,
		T2C_RELOAD = 4'h2,
		T2C_CAPTURE = 4'h4,
		T2C_BAUD = 4'h8
	} t2c_mode_type;

	// mode decode from control bits
	function automatic t2c_mode_type t2c_mode(input logic [7:0] ctl);
		if (!ctl[CTL_RUN])
			return T2C_OFF;
		else if (ctl[CTL_RXCLK] | ctl[CTL_TXCLK])
			return T2C_BAUD;
		else if (ctl[CTL_CAP])
			return T2C_CAPTURE;
		else
			return T2C_RELOAD;
	endfunction
endpackage

module t2c_timer #(
	parameter int MACH_DIV = t2c_pkg::MACHINE_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// software writes: one strobe per byte, shared data
	input wire logic [7:0] wr_data,
	input wire logic ctl_wr,
	input wire logic cnt_lo_wr,
	input wire logic cnt_hi_wr,
	input wire logic rld_lo_wr,
	input wire logic rld_hi_wr,
	// software reads
	output logic [7:0] ctl_rd,
	output logic [15:0] count_rd,
	output logic [15:0] reload_rd,
	// pins
	input wire logic count_input_pin,
	input wire logic trigger_input_pin,
	// other interrupt sources, same clock
	input wire logic ext_int_zero_flag,
	input wire logic timer_zero_overflow,
	input wire logic ext_int_one_flag,
	input wire logic timer_one_overflow,
	input wire logic serial_receive_flag,
	input wire logic serial_transmit_flag,
	// results
	output logic timer_irq,
	output logic int_pending,
	output logic [15:0] int_vector,
	output logic rx_baud_tick,
	output logic tx_baud_tick
);
	import t2c_pkg::*;

	// =================================================================
	// parameter check
	// the state tick is the prescaler's low bit, so an odd divider would break its rhythm
	if (MACH_DIV < 4 || MACH_DIV > 255 || MACH_DIV % STATE_CYCLES != 0) begin : g_bad_div
		$error("machine divider out of range or odd");
	end

	logic [7:0] div_q;
	logic state_tick;
	logic mach_tick;
	logic cnt_fall;
	logic trig_fall;
	logic [7:0] ctl_q;
	logic [15:0] cnt_q;
	logic [15:0] cnt_d;
	logic [15:0] rld_q;
	logic [15:0] rld_d;
	logic [3:0] rx_div_q;
	logic [3:0] tx_div_q;
	logic tf_set;
	logic ef_set;
	logic tick;
	logic rollover;
	logic trig;
	t2c_mode_type mode;

	// =================================================================
	// pin synchronisers
	t2c_edge_sync u_cnt_sync (
		.clk(clk),
		.reset(reset),
		.pin_in(count_input_pin),
		.fall_pulse(cnt_fall)
	);

	t2c_edge_sync u_trig_sync (
		.clk(clk),
		.reset(reset),
		.pin_in(trigger_input_pin),
		.fall_pulse(trig_fall)
	);

	// =================================================================
	// prescaler: state time every 2 cycles, machine cycle every MACH_DIV (12 by default)
	always_ff @(posedge clk) begin
		if (reset || div_q == 8'(MACH_DIV - 1)) begin
			div_q <= 8'h00;
		end else begin
			div_q <= div_q + 8'h01;
		end
	end

	assign mach_tick = (div_q == 8'(MACH_DIV - 1));
	assign state_tick = (div_q[0] == 1'b1); // STATE_CYCLES is two

	// =================================================================
	// mode and count events
	assign mode = t2c_mode(ctl_q);
	// counter function counts pin edges, timer function the prescaler
	assign tick = (mode != T2C_OFF) &
		(ctl_q[CTL_CT] ? cnt_fall :
		(mode == T2C_BAUD ? state_tick : mach_tick));
	assign rollover = tick & (cnt_q == CNT_MAX);
	assign trig = (mode != T2C_OFF) & ctl_q[CTL_TRIG_EN] & trig_fall;
	assign tf_set = rollover & (mode != T2C_BAUD);
	assign ef_set = trig;

	// =================================================================
	// count bytes: software write beats hardware
	always_comb begin
		cnt_d = cnt_q;
		if (cnt_lo_wr || cnt_hi_wr) begin
			if (cnt_lo_wr)
				cnt_d[7:0] = wr_data;
			if (cnt_hi_wr)
				cnt_d[15:8] = wr_data;
		end else if ((rollover && mode != T2C_CAPTURE) ||
				(trig && mode == T2C_RELOAD)) begin
			cnt_d = rld_q;
		end else if (tick) begin
			cnt_d = cnt_q + 16'h0001; // capture mode wraps to zero
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			cnt_q <= CNT_RESET;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// =================================================================
	// reload/capture bytes
	always_comb begin
		rld_d = rld_q;
		if (rld_lo_wr || rld_hi_wr) begin
			if (rld_lo_wr)
				rld_d[7:0] = wr_data;
			if (rld_hi_wr)
				rld_d[15:8] = wr_data;
		end else if (trig && mode == T2C_CAPTURE) begin
			rld_d = cnt_q;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rld_q <= RLD_RESET;
		end else begin
			rld_q <= rld_d;
		end
	end

	// =================================================================
	// control register; a hardware set wins over a software clear
	always_ff @(posedge clk) begin
		if (reset) begin
			ctl_q <= CTL_RESET;
		end else begin
			if (ctl_wr)
				ctl_q <= wr_data;
			if (tf_set)
				ctl_q[CTL_OVF] <= 1'b1;
			if (ef_set)
				ctl_q[CTL_EVT] <= 1'b1;
		end
	end

	// =================================================================
	// baud ticks: one per sixteen overflows, per direction
	always_ff @(posedge clk) begin
		if (reset) begin
			rx_div_q <= 4'h0;
			tx_div_q <= 4'h0;
			rx_baud_tick <= 1'b0;
			tx_baud_tick <= 1'b0;
		end else begin
			rx_baud_tick <= rollover && mode == T2C_BAUD && ctl_q[CTL_RXCLK] &&
				rx_div_q == BAUD_LAST;
			tx_baud_tick <= rollover && mode == T2C_BAUD && ctl_q[CTL_TXCLK] &&
				tx_div_q == BAUD_LAST;
			if (rollover && mode == T2C_BAUD && ctl_q[CTL_RXCLK])
				rx_div_q <= rx_div_q + 4'h1;
			if (rollover && mode == T2C_BAUD && ctl_q[CTL_TXCLK])
				tx_div_q <= tx_div_q + 4'h1;
		end
	end

	// =================================================================
	// interrupt request and vector; nothing here clears the flags
	always_ff @(posedge clk) begin
		if (reset) begin
			timer_irq <= 1'b0;
			int_pending <= 1'b0;
			int_vector <= VEC_EXT0;
		end else begin
			timer_irq <= ctl_q[CTL_OVF] | ctl_q[CTL_EVT];
			int_pending <= ext_int_zero_flag | timer_zero_overflow | ext_int_one_flag |
				timer_one_overflow | serial_receive_flag | serial_transmit_flag | timer_irq;
			// fixed priority; this timer comes last
			if (ext_int_zero_flag)
				int_vector <= VEC_EXT0;
			else if (timer_zero_overflow)
				int_vector <= VEC_TMR0;
			else if (ext_int_one_flag)
				int_vector <= VEC_EXT1;
			else if (timer_one_overflow)
				int_vector <= VEC_TMR1;
			else if (serial_receive_flag || serial_transmit_flag)
				int_vector <= VEC_SER;
			else
				int_vector <= VEC_TMR2;
		end
	end

	// read-back straight from the flops
	assign ctl_rd = ctl_q;
	assign count_rd = cnt_q;
	assign reload_rd = rld_q;

	// =================================================================
	// checks
	a_baud_no_ovf: assert property (@(posedge clk) disable iff (reset)
		mode == T2C_BAUD && rollover && !ctl_wr |=> !$rose(ctl_q[CTL_OVF]))
		else $error("overflow flag set in baud mode");
	a_reload_load: assert property (@(posedge clk) disable iff (reset)
		mode == T2C_RELOAD && rollover && !cnt_lo_wr && !cnt_hi_wr && !ctl_wr
		|=> cnt_q == $past(rld_q) && ctl_q[CTL_OVF])
		else $error("auto-reload rollover wrong");
	a_capture_copy: assert property (@(posedge clk) disable iff (reset)
		mode == T2C_CAPTURE && trig && !rld_lo_wr && !rld_hi_wr
		|=> rld_q == $past(cnt_q) && ctl_q[CTL_EVT])
		else $error("capture copy wrong");
	a_baud_trig_noload: assert property (@(posedge clk) disable iff (reset)
		mode == T2C_BAUD && trig && !rollover && !cnt_lo_wr && !cnt_hi_wr
		|=> cnt_q == $past(cnt_q) + 16'($past(tick)) && ctl_q[CTL_EVT])
		else $error("baud trigger reloaded");
	a_irq_or: assert property (@(posedge clk) disable iff (reset)
		##1 timer_irq == ($past(ctl_q[CTL_OVF]) | $past(ctl_q[CTL_EVT])))
		else $error("irq not or of flags");
	a_flag_sw_write: assert property (@(posedge clk) disable iff (reset)
		ctl_wr && !tf_set && !ef_set |=> ctl_q == $past(wr_data))
		else $error("software flag write lost");
	a_set_wins: assert property (@(posedge clk) disable iff (reset)
		tf_set |=> ctl_q[CTL_OVF])
		else $error("overflow set lost");
	// cycles since the last machine tick; the divider is too long for a repetition
	logic [7:0] mach_gap_q;
	always_ff @(posedge clk) begin
		if (reset || mach_tick) begin
			mach_gap_q <= 8'h00;
		end else begin
			mach_gap_q <= mach_gap_q + 8'h01;
		end
	end

	a_mach_rate: assert property (@(posedge clk) disable iff (reset)
		mach_tick |-> mach_gap_q == 8'(MACH_DIV - 1))
		else $error("machine tick period wrong");
	a_state_rate: assert property (@(posedge clk) disable iff (reset)
		state_tick |=> !state_tick ##1 state_tick)
		else $error("state tick not every two cycles");
	a_vec_low: assert property (@(posedge clk) disable iff (reset)
		ext_int_zero_flag |=> int_vector == VEC_EXT0)
		else $error("priority vector wrong");
	a_off_hold: assert property (@(posedge clk) disable iff (reset)
		mode == T2C_OFF && !cnt_lo_wr && !cnt_hi_wr |=> $stable(cnt_q))
		else $error("counting while off");

	c_reload_roll: cover property (@(posedge clk) mode == T2C_RELOAD && rollover);
	c_capture_trig: cover property (@(posedge clk) mode == T2C_CAPTURE && trig);
	c_baud_tick: cover property (@(posedge clk) rx_baud_tick);
	c_counter_edge: cover property (@(posedge clk) ctl_q[CTL_CT] && tick);
endmodule // t2c_timer
